// ==== core/serial_prog.sv ====
`timescale 1ns/1ns
`default_nettype none
module serial_prog #(
  parameter int FLASH_WAIT_CYC = serprog_pkg::FLASH_WAIT_CYC,
  parameter int EEPROM_WAIT_CYC = serprog_pkg::EEPROM_WAIT_CYC,
  parameter int ERASE_WAIT_CYC = serprog_pkg::ERASE_WAIT_CYC
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output logic program_busy_flag,
  output logic prog_enabled
);
  import serprog_pkg::*;

  // Pin synchronisers: bit 0 reset pin, bit 1 serial clock, bit 2 serial data in.
  logic [2:0] meta_q, sync_q;
  logic sck_prev_q;
  logic prog_mode, sck_s, mosi_s, rise, fall;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= PIN_SYNC_RST;
      sync_q <= PIN_SYNC_RST;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= {mosi, sck, prog_reset_n};
      sync_q <= meta_q;
      sck_prev_q <= sync_q[1];
    end
  end

  assign prog_mode = ~sync_q[0];
  assign sck_s = sync_q[1];
  assign mosi_s = sync_q[2];
  assign rise = sck_s && !sck_prev_q;
  assign fall = !sck_s && sck_prev_q;

  // Link state.
  logic [4:0] bit_q, bit_d;
  logic [31:0] in_q, in_d, shift_in;
  logic [7:0] out_q, out_d, rd_data;
  logic miso_q, miso_d, oe_q, oe_d, en_q, en_d, push_q, push_d, busy_q, busy_d;
  frame_s frame_q, frame_d, fin, rq, xf;
  logic wr_cmd, is_erase, fifo_in_ready, fifo_out_valid, pop;
  logic [31:0] fifo_out;

  // Executor state.
  exec_e ex_q, ex_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, wait_lim;
  logic [FLASH_AW-PAGE_AW-1:0] page_q, page_d, xf_page;
  logic [EE_AW-1:0] ee_addr_q, ee_addr_d;

  // Memories and their write ports.
  logic [7:0] flash_lo [FLASH_WORDS];
  logic [7:0] flash_hi [FLASH_WORDS];
  logic [7:0] eeprom [EE_BYTES];
  logic [7:0] pbuf_lo [PAGE_WORDS];
  logic [7:0] pbuf_hi [PAGE_WORDS];
  logic fl_we, ee_we, pb_we, pb_hi, pb_clr;
  logic [FLASH_AW-1:0] fl_wa, fl_ra;
  logic [7:0] fl_wlo, fl_whi, ee_wd, pb_wd;
  logic [EE_AW-1:0] ee_wa, ee_ra;
  logic [PAGE_AW-1:0] pb_wa, pb_ca;

  assign shift_in = {in_q[30:0], mosi_s};
  assign fin = frame_s'(shift_in);
  // Fields of the frame as known after three bytes, used for the read answer.
  assign rq = frame_s'({shift_in[23:0], ZERO_BYTE});
  assign is_erase = fin.op == OP_PROG_EN && (fin.addr_hi & ERASE_MASK) == ERASE_VAL;
  assign wr_cmd = is_erase || (fin.op & H_MASK) == OP_LD_PAGE || fin.op == OP_WR_PAGE || fin.op == OP_WR_EE;
  assign fl_ra = {rq.addr_hi[4:0], rq.addr_lo};
  assign ee_ra = {rq.addr_hi[1:0], rq.addr_lo};

  // Reads bypass the FIFO so that the answer is ready for the fourth byte slot.
  always_comb
  begin
    rd_data = ZERO_BYTE;
    if ((rq.op & H_MASK) == OP_RD_FLASH)
    begin
      if (ex_q == EX_ERASE || (ex_q == EX_FLASH && fl_ra[FLASH_AW-1:PAGE_AW] == page_q))
      begin
        rd_data = ERASED_BYTE;
      end
      else
      begin
        rd_data = rq.op[H_BIT] ? flash_hi[fl_ra] : flash_lo[fl_ra];
      end
    end
    else if (rq.op == OP_RD_EE)
    begin
      if (ex_q == EX_ERASE || (ex_q == EX_EEPROM && ee_ra == ee_addr_q))
      begin
        rd_data = ERASED_BYTE;
      end
      else
      begin
        rd_data = eeprom[ee_ra];
      end
    end
    else if (rq.op == OP_POLL)
    begin
      rd_data = {7'h00, busy_q};
    end
  end

  always_comb
  begin
    bit_d = bit_q;
    in_d = in_q;
    out_d = out_q;
    miso_d = miso_q;
    en_d = en_q;
    push_d = 1'b0;
    frame_d = frame_q;
    oe_d = prog_mode;
    if (!prog_mode)
    begin
      // A reset pulse is the only way to regain frame alignment.
      bit_d = '0;
      en_d = 1'b0;
      out_d = ZERO_BYTE;
      miso_d = 1'b0;
    end
    else if (rise)
    begin
      in_d = shift_in;
      bit_d = bit_q + BIT_ONE;
      if (bit_q[2:0] == BYTE_END)
      begin
        out_d = (bit_q == BYTE3_DONE) ? rd_data : shift_in[7:0];
        if (bit_q == FRAME_DONE)
        begin
          out_d = ZERO_BYTE;
          if (!en_q)
          begin
            en_d = fin.op == OP_PROG_EN && fin.addr_hi == PE_KEY;
          end
          else if (wr_cmd && fifo_in_ready)
          begin
            push_d = 1'b1;
            frame_d = fin;
          end
        end
      end
    end
    else if (fall)
    begin
      miso_d = out_q[7];
      out_d = {out_q[6:0], 1'b0};
    end
  end

  serprog_fifo #(
    .WIDTH($bits(frame_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk(sys_clk),
    .rst(rst),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(frame_q),
    .out_valid(fifo_out_valid),
    .out_ready(ex_q == EX_IDLE),
    .out_data(fifo_out)
  );

  assign xf = frame_s'(fifo_out);
  assign xf_page = {xf.addr_hi[4:0], xf.addr_lo[7:PAGE_AW]};

  always_comb
  begin
    unique case (ex_q)
      EX_ERASE: wait_lim = CNT_W'(ERASE_WAIT_CYC - 1);
      EX_FLASH: wait_lim = CNT_W'(FLASH_WAIT_CYC - 1);
      EX_IDLE, EX_EEPROM: wait_lim = CNT_W'(EEPROM_WAIT_CYC - 1);
    endcase
  end

  always_comb
  begin
    ex_d = ex_q;
    cnt_d = cnt_q;
    page_d = page_q;
    ee_addr_d = ee_addr_q;
    pop = 1'b0;
    fl_we = 1'b0;
    fl_wa = cnt_q[FLASH_AW-1:0];
    fl_wlo = ERASED_BYTE;
    fl_whi = ERASED_BYTE;
    ee_we = 1'b0;
    ee_wa = cnt_q[EE_AW-1:0];
    ee_wd = ERASED_BYTE;
    pb_we = 1'b0;
    pb_hi = 1'b0;
    pb_wa = xf.addr_lo[PAGE_AW-1:0];
    pb_wd = xf.data;
    pb_clr = 1'b0;
    pb_ca = cnt_q[PAGE_AW-1:0];
    busy_d = 1'b1;
    unique case (ex_q)
      EX_IDLE:
      begin
        cnt_d = '0;
        if (fifo_out_valid)
        begin
          pop = 1'b1;
          if (xf.op == OP_PROG_EN)
          begin
            ex_d = EX_ERASE;
          end
          else if (xf.op == OP_WR_PAGE)
          begin
            ex_d = EX_FLASH;
            page_d = xf_page;
          end
          else if (xf.op == OP_WR_EE)
          begin
            // The cell is rewritten whole, so no separate erase step is needed.
            ex_d = EX_EEPROM;
            ee_we = 1'b1;
            ee_wa = {xf.addr_hi[1:0], xf.addr_lo};
            ee_wd = xf.data;
            ee_addr_d = {xf.addr_hi[1:0], xf.addr_lo};
          end
          else
          begin
            pb_we = 1'b1;
            pb_hi = xf.op[H_BIT];
          end
        end
      end
      EX_ERASE:
      begin
        fl_we = cnt_q < CNT_W'(FLASH_WORDS);
        ee_we = cnt_q < CNT_W'(EE_BYTES);
        pb_clr = cnt_q < CNT_W'(PAGE_WORDS);
      end
      EX_FLASH:
      begin
        fl_we = cnt_q < CNT_W'(PAGE_WORDS);
        fl_wa = {page_q, cnt_q[PAGE_AW-1:0]};
        fl_wlo = pbuf_lo[cnt_q[PAGE_AW-1:0]];
        fl_whi = pbuf_hi[cnt_q[PAGE_AW-1:0]];
        pb_clr = fl_we;
      end
      EX_EEPROM:
      begin
      end
    endcase
    if (ex_q != EX_IDLE)
    begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == wait_lim)
      begin
        ex_d = EX_IDLE;
      end
    end
    if (ex_d == EX_IDLE && !fifo_out_valid && !push_d && !push_q)
    begin
      busy_d = 1'b0;
    end
  end

  // Memories are not reset; a chip erase is what gives them a known content.
  always_ff @(posedge sys_clk)
  begin
    if (fl_we)
    begin
      flash_lo[fl_wa] <= fl_wlo;
      flash_hi[fl_wa] <= fl_whi;
    end
    if (ee_we)
    begin
      eeprom[ee_wa] <= ee_wd;
    end
    if (pb_clr)
    begin
      pbuf_lo[pb_ca] <= ERASED_BYTE;
      pbuf_hi[pb_ca] <= ERASED_BYTE;
    end
    else if (pb_we && pb_hi)
    begin
      pbuf_hi[pb_wa] <= pb_wd;
    end
    else if (pb_we)
    begin
      pbuf_lo[pb_wa] <= pb_wd;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bit_q <= '0;
      in_q <= '0;
      out_q <= '0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
      en_q <= 1'b0;
      push_q <= 1'b0;
      frame_q <= '0;
      busy_q <= 1'b0;
      ex_q <= EX_IDLE;
      cnt_q <= '0;
      page_q <= '0;
      ee_addr_q <= '0;
    end
    else
    begin
      bit_q <= bit_d;
      in_q <= in_d;
      out_q <= out_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
      en_q <= en_d;
      push_q <= push_d;
      frame_q <= frame_d;
      busy_q <= busy_d;
      ex_q <= ex_d;
      cnt_q <= cnt_d;
      page_q <= page_d;
      ee_addr_q <= ee_addr_d;
    end
  end

  assign miso = miso_q;
  assign miso_oe = oe_q;
  assign prog_enabled = en_q;
  assign program_busy_flag = busy_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sample_rise_a: assert property (prog_mode && rise |=> in_q[0] == $past(mosi_s))
    else $error("Data bit not taken on clock rise.");
  miso_edge_a: assert property ($changed(miso_q) && prog_mode |-> $past(fall))
    else $error("Serial output moved away from a falling edge.");
  msb_first_a: assert property (prog_mode && fall |=> miso_q == $past(out_q[7]))
    else $error("Serial output not most significant bit first.");
  echo_byte_a: assert property (prog_mode && rise && bit_q == BYTE2_DONE |=> out_q == $past(shift_in[7:0]))
    else $error("Second byte not echoed.");
  enable_key_a: assert property (prog_mode && rise && bit_q == FRAME_DONE && !en_q
    && fin.op == OP_PROG_EN && fin.addr_hi == PE_KEY |=> en_q)
    else $error("Enable instruction not accepted.");
  enable_drop_a: assert property (!prog_mode |=> !en_q && !oe_q)
    else $error("Enable survived reset pin release.");
  read_answer_a: assert property (prog_mode && rise && bit_q == BYTE3_DONE |=> out_q == $past(rd_data))
    else $error("Read answer not loaded for byte four.");
  flash_poll_a: assert property (ex_q == EX_FLASH && (rq.op & H_MASK) == OP_RD_FLASH
    && fl_ra[FLASH_AW-1:PAGE_AW] == page_q |-> rd_data == ERASED_BYTE)
    else $error("Busy flash page not reading erased.");
  ee_poll_a: assert property (ex_q == EX_EEPROM && rq.op == OP_RD_EE && ee_ra == ee_addr_q
    |-> rd_data == ERASED_BYTE)
    else $error("Busy eeprom byte not reading erased.");
  erase_start_a: assert property (pop && xf.op == OP_PROG_EN |=> ex_q == EX_ERASE && cnt_q == '0 && busy_q)
    else $error("Chip erase did not start.");
  page_commit_a: assert property (pop && xf.op == OP_WR_PAGE |=> ex_q == EX_FLASH
    && page_q == $past(xf_page))
    else $error("Page write took wrong page.");
  busy_flag_a: assert property (ex_q != EX_IDLE |-> busy_q)
    else $error("Busy flag low while an operation runs.");

  erase_seen_c: cover property (ex_q == EX_ERASE ##1 ex_q == EX_IDLE);
  page_seen_c: cover property (ex_q == EX_FLASH ##1 ex_q == EX_IDLE);
  enable_seen_c: cover property ($rose(en_q));
endmodule
`default_nettype wire

// ==== core/serprog_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module serprog_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== core/serprog_pkg.sv ====
package serprog_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int FLASH_WAIT_US = 4500;
  localparam int EEPROM_WAIT_US = 3600;
  localparam int ERASE_WAIT_US = 9000;
  // The device finishes within the programmer's minimum wait, so counts round down.
  localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 17;

  localparam int FLASH_AW = 13;
  localparam int PAGE_AW = 6;
  localparam int EE_AW = 10;
  localparam int FLASH_WORDS = 8192;
  localparam int PAGE_WORDS = 64;
  localparam int EE_BYTES = 1024;
  localparam int FIFO_DEPTH = 16;

  localparam logic [4:0] BIT_ONE = 5'h01;
  localparam logic [4:0] BYTE2_DONE = 5'h0f;
  localparam logic [4:0] BYTE3_DONE = 5'h17;
  localparam logic [4:0] FRAME_DONE = 5'h1f;
  localparam logic [2:0] BYTE_END = 3'h7;
  localparam logic [2:0] PIN_SYNC_RST = 3'h1;

  localparam logic [7:0] OP_PROG_EN = 8'hac;
  localparam logic [7:0] PE_KEY = 8'h53;
  localparam logic [7:0] ERASE_MASK = 8'he0;
  localparam logic [7:0] ERASE_VAL = 8'h80;
  localparam logic [7:0] H_MASK = 8'hf7;
  localparam int H_BIT = 3;
  localparam logic [7:0] OP_RD_FLASH = 8'h20;
  localparam logic [7:0] OP_LD_PAGE = 8'h40;
  localparam logic [7:0] OP_WR_PAGE = 8'h4c;
  localparam logic [7:0] OP_RD_EE = 8'ha0;
  localparam logic [7:0] OP_WR_EE = 8'hc0;
  localparam logic [7:0] OP_POLL = 8'hf0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] data;
  } frame_s;

  typedef enum logic [1:0] {EX_IDLE, EX_ERASE, EX_FLASH, EX_EEPROM} exec_e;
endpackage

// ==== tb/prog_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module prog_model (
  input wire logic sys_clk,
  input wire logic miso,
  output logic sck,
  output logic mosi
);
  initial
  begin
    sck = 1'b0;
    mosi = 1'b0;
  end

  // Shifts one whole frame and keeps what the device returned at each rising edge.
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0000_0000;
    for (int i = 31; i >= 0; i--)
    begin
      mosi = tx[i];
      repeat (4) @(negedge sys_clk);
      sck = 1'b1;
      rx = {rx[30:0], miso};
      repeat (4) @(negedge sys_clk);
      sck = 1'b0;
    end
    // A stale data level would hide a device that samples outside the frame.
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  import serprog_pkg::*;
  localparam int FLASH_CYC = 400;
  localparam int EE_CYC = 400;
  localparam int ERASE_CYC = 9000;
  localparam int LIMIT = 60000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic prog_reset_n = 1'b0;
  logic sck, mosi, miso, miso_oe, program_busy_flag, prog_enabled;
  logic sck_p = 1'b0;
  logic miso_p = 1'b0;
  logic [31:0] rx;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int fall_cnt = 0;

  always #50 sys_clk = ~sys_clk;

  serial_prog #(.FLASH_WAIT_CYC(FLASH_CYC), .EEPROM_WAIT_CYC(EE_CYC), .ERASE_WAIT_CYC(ERASE_CYC)) u_serial_prog (
    .sys_clk(sys_clk),
    .rst(rst),
    .prog_reset_n(prog_reset_n),
    .sck(sck),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .program_busy_flag(program_busy_flag),
    .prog_enabled(prog_enabled)
  );

  prog_model u_prog_model (.sys_clk(sys_clk), .miso(miso), .sck(sck), .mosi(mosi));

  task end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task send(input logic [31:0] tx);
    u_prog_model.xfer(tx, rx);
  endtask

  task wait_idle;
    int n;
    n = 0;
    while (program_busy_flag !== 1'b0 && n < 20000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("busy_end", 8'h00, {7'h00, program_busy_flag});
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      $display("Error cycle_limit: expected below %0d, seen %0d", LIMIT, cycles);
      end_sim();
    end
  end

  // Read data may only move on the fourth edge after the serial clock fell.
  always @(posedge sys_clk)
  begin
    if (sck_p && !sck)
      fall_cnt = 1;
    else
      fall_cnt++;
    sck_p = sck;
    if (miso_oe === 1'b1 && !prog_reset_n && miso !== miso_p)
      chk("miso_edge", 8'h04, fall_cnt[7:0]);
    miso_p = miso;
  end

  task t_enable;
    chk("enabled_before", 8'h00, {7'h00, prog_enabled});
    chk("oe_session", 8'h01, {7'h00, miso_oe});
    send({OP_WR_EE, 8'h00, 8'h10, 8'h77});
    chk("busy_locked", 8'h00, {7'h00, program_busy_flag});
    send({OP_PROG_EN, PE_KEY, 8'h00, 8'h00});
    chk("echo_op", OP_PROG_EN, rx[23:16]);
    chk("echo_key", PE_KEY, rx[15:8]);
    chk("enabled", 8'h01, {7'h00, prog_enabled});
    $display("t_enable done");
  endtask

  task t_erase;
    logic [7:0] rd [4];
    rd = '{OP_RD_FLASH, OP_RD_FLASH | 8'h08, OP_RD_EE, OP_RD_EE};
    send({OP_PROG_EN, 8'h9f, 8'h00, 8'h00});
    chk("erase_busy", 8'h01, {7'h00, program_busy_flag});
    send({OP_POLL, 8'h00, 8'h00, 8'h00});
    chk("poll_busy", 8'h01, {7'h00, rx[0]});
    wait_idle();
    send({OP_POLL, 8'h00, 8'h00, 8'h00});
    chk("poll_idle", 8'h00, {7'h00, rx[0]});
    for (int i = 0; i < 4; i++)
    begin
      send({rd[i], (i % 2 == 1) ? 8'h1f : 8'h03, 8'hff, 8'h00});
      chk("erased", ERASED_BYTE, rx[7:0]);
    end
    $display("t_erase done");
  endtask

  task t_eeprom;
    logic [7:0] v [3];
    // The last value rewrites the location with erased data, which polling cannot see.
    v = '{8'h5a, 8'ha5, ERASED_BYTE};
    for (int i = 0; i < 3; i++)
    begin
      send({OP_WR_EE, 8'h03, 8'hff, v[i]});
      chk("ee_busy", 8'h01, {7'h00, program_busy_flag});
      send({OP_RD_EE, 8'h03, 8'hff, 8'h00});
      chk("ee_poll", ERASED_BYTE, rx[7:0]);
      wait_idle();
      send({OP_RD_EE, 8'h1f, 8'hff, 8'h00});
      chk("ee_data", v[i], rx[7:0]);
    end
    $display("t_eeprom done");
  endtask

  task t_flash;
    send({OP_LD_PAGE, 8'h1f, 8'hff, 8'h12});
    send({OP_LD_PAGE | 8'h08, 8'h1f, 8'hff, 8'h34});
    send({OP_WR_PAGE, 8'h1f, 8'hc0, 8'h00});
    chk("page_busy", 8'h01, {7'h00, program_busy_flag});
    send({OP_RD_FLASH, 8'h1f, 8'hff, 8'h00});
    chk("page_poll", ERASED_BYTE, rx[7:0]);
    wait_idle();
    send({OP_RD_FLASH, 8'h1f, 8'hff, 8'h00});
    chk("flash_low", 8'h12, rx[7:0]);
    send({OP_RD_FLASH | 8'h08, 8'h1f, 8'hff, 8'h00});
    chk("flash_high", 8'h34, rx[7:0]);
    send({OP_RD_FLASH, 8'h1f, 8'hbf, 8'h00});
    chk("other_page", ERASED_BYTE, rx[7:0]);
    $display("t_flash done");
  endtask

  task t_session;
    prog_reset_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk("enabled_off", 8'h00, {7'h00, prog_enabled});
    chk("oe_off", 8'h00, {7'h00, miso_oe});
    prog_reset_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    t_enable();
    $display("t_session done");
  endtask

  initial
  begin
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    // The long settling wait before enable is shortened; the block needs only the sync delay.
    repeat (8) @(negedge sys_clk);
    t_enable();
    t_erase();
    t_eeprom();
    t_flash();
    t_session();
    end_sim();
  end
endmodule
`default_nettype wire
